// *** hdl/tce_top.sv ***
// Trigger-to-channel enable bank with software channel events
//
// The placing of the registers and the strobed register port were left to the implementer.
module tce_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [tce_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tce_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tce_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [tce_pkg::NUM_TRIG-1:0] trig_in,
    output logic [tce_pkg::NUM_CHAN-1:0] chan_event
);
    localparam int NC = tce_pkg::NUM_CHAN;
    localparam int NT = tce_pkg::NUM_TRIG;

    tce_pkg::tce_bus_s bus;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [NC-1:0] mask_reg [NT];
    logic [NC-1:0] app_reg;
    logic [NC-1:0] pulse_reg;
    logic [NC-1:0] event_reg;
    logic [tce_pkg::DATA_W-1:0] rdata_reg;
    logic [NT-1:0] trig_sync;

    // Trigger inputs come from another domain, so they are synchronised first
    tce_sync #(.WIDTH(NT)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(trig_in),
        .dout(trig_sync)
    );

    // Address decode
    wire [NT-1:0] mask_sel;
    wire set_sel = bus.addr == tce_pkg::APP_SET_OFS;
    wire clr_sel = bus.addr == tce_pkg::APP_CLEAR_OFS;
    wire pls_sel = bus.addr == tce_pkg::APP_PULSE_OFS;
    wire tst_sel = bus.addr == tce_pkg::TRIG_STATUS_OFS;
    wire cst_sel = bus.addr == tce_pkg::CHAN_STATUS_OFS;

    // Per-input mask decode and routing; OR of enabled inputs per channel
    wire [NC-1:0] routed [NT];
    wire [NC-1:0] trig_or [NT+1];
    assign trig_or[0] = '0;
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi++) begin : g_trig
            assign mask_sel[gi] = bus.addr ==
                8'(tce_pkg::TRIGGER0_CHANNEL_MASK_OFS + gi * tce_pkg::WORD_STRIDE);
            assign routed[gi] = {NC{trig_sync[gi]}} & mask_reg[gi];
            assign trig_or[gi+1] = trig_or[gi] | routed[gi];
            // Only bits 3:0 are stored; upper written bits fall away
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    mask_reg[gi] <= tce_pkg::MASK_RESET;
                end else if (bus.wr && mask_sel[gi]) begin
                    mask_reg[gi] <= bus.wdata[NC-1:0];
                end
            end
        end
    endgenerate

    // Software path bypasses the masks entirely, so masks cannot block it
    wire [NC-1:0] sw_event = app_reg | pulse_reg;
    wire [NC-1:0] event_next = trig_or[NT] | sw_event;

    // Application set and clear; set wins a same-cycle clash
    wire [NC-1:0] set_bits = (bus.wr && set_sel) ? bus.wdata[NC-1:0] : '0;
    wire [NC-1:0] clr_bits = (bus.wr && clr_sel) ? bus.wdata[NC-1:0] : '0;
    wire [NC-1:0] app_next = set_bits | (app_reg & ~clr_bits);
    wire [NC-1:0] pulse_next = (bus.wr && pls_sel) ? bus.wdata[NC-1:0] : '0;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            app_reg <= tce_pkg::APP_RESET;
            pulse_reg <= tce_pkg::APP_RESET;
            event_reg <= '0;
        end else begin
            app_reg <= app_next;
            pulse_reg <= pulse_next; // Self-clearing one-cycle pulse
            event_reg <= event_next;
        end
    end
    assign chan_event = event_reg;

    // Read mux: reserved bits and unmapped words read zero
    logic [NC-1:0] mask_rd;
    always_comb begin
        mask_rd = '0;
        for (int i = 0; i < NT; i++) begin
            if (mask_sel[i]) begin
                mask_rd = mask_reg[i];
            end
        end
    end
    wire any_mask = |mask_sel;
    wire [tce_pkg::DATA_W-1:0] rd_next =
        any_mask ? {{(tce_pkg::DATA_W-NC){1'b0}}, mask_rd} :
        set_sel ? {{(tce_pkg::DATA_W-NC){1'b0}}, app_reg} :
        tst_sel ? {{(tce_pkg::DATA_W-NT){1'b0}}, trig_sync} :
        cst_sel ? {{(tce_pkg::DATA_W-NC){1'b0}}, event_reg} :
        tce_pkg::UNMAPPED_READ;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= bus.rd ? rd_next : '0;
        end
    end
    assign reg_rdata = rdata_reg;

    // Assertions
    property p_mask_store;
        @(posedge mclk) disable iff (sys_rst)
        (reg_wr && mask_sel[1]) |=> mask_reg[1] == $past(reg_wdata[NC-1:0]);
    endproperty
    a_mask_store: assert property (p_mask_store) else $error("mask write lost");
    property p_in1;
        @(posedge mclk) disable iff (sys_rst)
        (trig_sync[1] && mask_reg[1][0]) |=> chan_event[0];
    endproperty
    a_in1: assert property (p_in1) else $error("input 1 event missing");
    property p_in2;
        @(posedge mclk) disable iff (sys_rst)
        (trig_sync[2] && mask_reg[2][1]) |=> chan_event[1];
    endproperty
    a_in2: assert property (p_in2) else $error("input 2 event missing");
    property p_in3;
        @(posedge mclk) disable iff (sys_rst)
        (trig_sync[3] && mask_reg[3][2]) |=> chan_event[2];
    endproperty
    a_in3: assert property (p_in3) else $error("input 3 event missing");
    property p_in4;
        @(posedge mclk) disable iff (sys_rst)
        (trig_sync[4] && mask_reg[4][3]) |=> chan_event[3];
    endproperty
    a_in4: assert property (p_in4) else $error("input 4 event missing");
    property p_sw;
        @(posedge mclk) disable iff (sys_rst)
        (reg_wr && pls_sel && reg_wdata[0]) |=> ##1 chan_event[0];
    endproperty
    a_sw: assert property (p_sw) else $error("pulse blocked");
    property p_in0;
        @(posedge mclk) disable iff (sys_rst)
        (trig_sync[0] && mask_reg[0][0]) |=> chan_event[0];
    endproperty
    a_in0: assert property (p_in0) else $error("input 0 event missing");
    property p_quiet;
        @(posedge mclk) disable iff (sys_rst)
        (trig_sync == '0 && sw_event == '0) |=> chan_event == '0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("spurious event");
    property p_rsvd;
        @(posedge mclk) disable iff (sys_rst)
        (reg_rd && any_mask) |=> reg_rdata[tce_pkg::DATA_W-1:NC] == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
    // Each input alone must light exactly the channels its mask enables
    property p_only1;
        @(posedge mclk) disable iff (sys_rst)
        ($onehot(trig_sync) && trig_sync[1] && sw_event == '0)
            |=> chan_event == $past(mask_reg[1]);
    endproperty
    a_only1: assert property (p_only1) else $error("input 1 routing wrong");
    property p_only2;
        @(posedge mclk) disable iff (sys_rst)
        ($onehot(trig_sync) && trig_sync[2] && sw_event == '0)
            |=> chan_event == $past(mask_reg[2]);
    endproperty
    a_only2: assert property (p_only2) else $error("input 2 routing wrong");
    property p_only3;
        @(posedge mclk) disable iff (sys_rst)
        ($onehot(trig_sync) && trig_sync[3] && sw_event == '0)
            |=> chan_event == $past(mask_reg[3]);
    endproperty
    a_only3: assert property (p_only3) else $error("input 3 routing wrong");
    property p_only4;
        @(posedge mclk) disable iff (sys_rst)
        ($onehot(trig_sync) && trig_sync[4] && sw_event == '0)
            |=> chan_event == $past(mask_reg[4]);
    endproperty
    a_only4: assert property (p_only4) else $error("input 4 routing wrong");
    property p_only0;
        @(posedge mclk) disable iff (sys_rst)
        ($onehot(trig_sync) && trig_sync[0] && sw_event == '0)
            |=> chan_event == $past(mask_reg[0]);
    endproperty
    a_only0: assert property (p_only0) else $error("input 0 routing wrong");
    // Pulse lands two edges after its write, whatever the masks hold
    sequence s_pulse_req;
        reg_wr && pls_sel;
    endsequence
    sequence s_pulse_out;
        ##2 (chan_event & $past(reg_wdata[NC-1:0], 2)) == $past(reg_wdata[NC-1:0], 2);
    endsequence
    property p_pulse_all;
        @(posedge mclk) disable iff (sys_rst)
        s_pulse_req |-> s_pulse_out;
    endproperty
    a_pulse_all: assert property (p_pulse_all) else $error("pulse lost on a channel");
    // A set software event stays on its channels until cleared
    property p_set_event;
        @(posedge mclk) disable iff (sys_rst)
        (app_reg != '0) |=> (chan_event & $past(app_reg)) == $past(app_reg);
    endproperty
    a_set_event: assert property (p_set_event) else $error("set event blocked");
    property p_clr;
        @(posedge mclk) disable iff (sys_rst)
        (reg_wr && clr_sel) |=> (app_reg & $past(reg_wdata[NC-1:0])) == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("clear left a channel set");
    property p_mask_read;
        @(posedge mclk) disable iff (sys_rst)
        (reg_rd && mask_sel[2])
            |=> reg_rdata == {{(tce_pkg::DATA_W-NC){1'b0}}, $past(mask_reg[2])};
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read wrong");
    property p_mask_keep;
        @(posedge mclk) disable iff (sys_rst)
        !(reg_wr && mask_sel[3]) |=> $stable(mask_reg[3]);
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask moved unwritten");
    // Read data drops back to zero outside its one cycle
    property p_rd_idle;
        @(posedge mclk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == tce_pkg::UNMAPPED_READ;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
endmodule : tce_top

// *** hdl/tce_pkg.sv ***
// How it works
// - Each trigger input owns a 4-bit mask, one bit per channel, in bits 3:0.
// - Input 1 firing raises events only on channels enabled in its mask.
// - Input 2 firing raises events only on channels enabled in its mask.
// - Input 3 firing raises events only on channels enabled in its mask.
// - Input 4 firing raises events only on channels enabled in its mask.
// - Masks never gate the software set, clear and pulse channel events.
// - Input 0 uses the same scheme with its own mask.
package tce_pkg;
    localparam int NUM_CHAN = 4;
    localparam int NUM_TRIG = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets, one word per trigger mask
    localparam logic [7:0] TRIGGER0_CHANNEL_MASK_OFS = 8'h00;
    localparam logic [7:0] TRIGGER1_CHANNEL_MASK_OFS = 8'h04;
    localparam logic [7:0] TRIGGER2_CHANNEL_MASK_OFS = 8'h08;
    localparam logic [7:0] TRIGGER3_CHANNEL_MASK_OFS = 8'h0C;
    localparam logic [7:0] TRIGGER4_CHANNEL_MASK_OFS = 8'h10;
    localparam logic [7:0] APP_SET_OFS = 8'h14;
    localparam logic [7:0] APP_CLEAR_OFS = 8'h18;
    localparam logic [7:0] APP_PULSE_OFS = 8'h1C;
    localparam logic [7:0] TRIG_STATUS_OFS = 8'h20;
    localparam logic [7:0] CHAN_STATUS_OFS = 8'h24;
    localparam logic [7:0] WORD_STRIDE = 8'h04;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [3:0] APP_RESET = 4'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } tce_bus_s;
endpackage : tce_pkg

// *** hdl/tce_sync.sv ***
// Three-stage input synchroniser; a change counts once stages two and three agree
module tce_sync #(
    parameter int WIDTH = 5
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

    // Stage one feeds only stage two
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= (agree & s3_reg) | (~agree & out_reg);
        end
    end
    assign dout = out_reg;
endmodule : tce_sync

// *** sim/tce_trig_src.sv ***
// Trigger sources: each level is registered on the clock edge, like source logic
module tce_trig_src (
    input wire logic mclk,
    input wire logic [tce_pkg::NUM_TRIG-1:0] level,
    output logic [tce_pkg::NUM_TRIG-1:0] trig_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Non-blocking on the edge, so the block never sees a level mid-step
    always @(posedge mclk) begin
        trig_in <= level;
    end
endmodule : tce_trig_src

// *** sim/testbench.sv ***
`define CHK(got, exp) check(got, exp)
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [4:0] level = 5'h00;
    logic [4:0] trig_in;
    logic [3:0] chan_event;
    logic [3:0] pat [5] = '{4'h1, 4'h6, 4'hA, 4'hF, 4'h9};
    int miscompares = 0;
    int compares = 0;
    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;
    tce_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trig_in(trig_in), .chan_event(chan_event));
    tce_trig_src i_src (.mclk(mclk), .level(level), .trig_in(trig_in));
    // Four-state compare so an unknown never passes
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : bus_wr
    // Read data is only valid in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : bus_rd
    // Masks: reset value, write with upper bits all ones keeps only bits 3:0, unmapped reads zero
    task automatic t_regs();
        logic [31:0] d;
        for (int k = 0; k < 5; k++) begin
            bus_rd(8'(4 * k), d);
            `CHK(d, {28'h0, tce_pkg::MASK_RESET});
            bus_wr(8'(4 * k), {28'hFFF_FFFF, pat[k]});
            bus_rd(8'(4 * k), d);
            `CHK(d, {28'h0, pat[k]});
        end
        bus_rd(8'h3C, d);
        `CHK(d, tce_pkg::UNMAPPED_READ);
    endtask : t_regs
    // Each input alone must light exactly its enabled channels
    task automatic t_trig();
        logic [31:0] d;
        for (int k = 0; k < 5; k++) begin
            @(posedge mclk);
            level <= 5'(1 << k);
            repeat (8) @(posedge mclk);
            #1 `CHK(chan_event, pat[k]);
            bus_rd(tce_pkg::TRIG_STATUS_OFS, d);
            `CHK(d, 32'(1 << k));
            @(posedge mclk);
            level <= 5'h00;
            repeat (8) @(posedge mclk);
            #1 `CHK(chan_event, 4'h0);
        end
    endtask : t_trig
    // Software events with every mask cleared, so a mask-gated path would show
    task automatic t_app();
        logic [31:0] d;
        for (int k = 0; k < 5; k++) begin
            bus_wr(8'(4 * k), 32'h0000_0000);
        end
        bus_wr(tce_pkg::APP_SET_OFS, 32'h0000_000A);
        repeat (2) @(posedge mclk);
        #1 `CHK(chan_event, 4'hA);
        bus_rd(tce_pkg::APP_SET_OFS, d);
        `CHK(d, 32'h0000_000A);
        bus_rd(tce_pkg::CHAN_STATUS_OFS, d);
        `CHK(d, 32'h0000_000A);
        bus_wr(tce_pkg::APP_CLEAR_OFS, 32'h0000_000A);
        repeat (2) @(posedge mclk);
        #1 `CHK(chan_event, 4'h0);
        bus_wr(tce_pkg::APP_PULSE_OFS, 32'h0000_0005);
        @(posedge mclk);
        #1 `CHK(chan_event, 4'h5);
        @(posedge mclk);
        #1 `CHK(chan_event, 4'h0);
    endtask : t_app
    // Reset in mid-run must drop masks, software events and channel outputs
    task automatic t_reset();
        logic [31:0] d;
        bus_wr(tce_pkg::TRIGGER1_CHANNEL_MASK_OFS, 32'h0000_000F);
        bus_wr(tce_pkg::APP_SET_OFS, 32'h0000_0003);
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 `CHK(chan_event, 4'h0);
        bus_rd(tce_pkg::TRIGGER1_CHANNEL_MASK_OFS, d);
        `CHK(d, {28'h0, tce_pkg::MASK_RESET});
        bus_rd(tce_pkg::APP_SET_OFS, d);
        `CHK(d, {28'h0, tce_pkg::APP_RESET});
    endtask : t_reset
    task automatic summarize();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_trig();
        t_app();
        t_reset();
        summarize();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule : testbench
